// *** src/filter_tune_pkg.sv ***
// Shared constants and types for the input filter auto-tune sequencer
package filter_tune_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FILT = 8'h04;
    localparam logic [7:0] ADDR_SEAL = 8'h08;
    localparam logic [7:0] ADDR_HUNT = 8'h0c;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
    localparam logic [7:0] ADDR_FILT_OUT = 8'h20;
    // Field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_AT_BIT = 3;
    localparam int CTRL_LEVEL_BIT = 4;
    localparam int CTRL_COMM_BIT = 5;
    localparam int MODE_PID_BIT = 0;
    localparam int MODE_STD_BIT = 1;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_CANCEL_BIT = 1;
    localparam int IRQ_SKIP_BIT = 2;
    // Widths
    localparam int FILT_W = 14;
    localparam int SEAL_W = 7;
    localparam int HUNT_W = 11;
    localparam int DATA_W = 16;
    // Reset values and ranges (filter and seal in 0.1 s, hunting in 1 s)
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [1:0] MODE_RST = 2'h3;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam logic [FILT_W-1:0] FILT_RST = 14'h0000;
    localparam logic [FILT_W-1:0] FILT_MAX = 14'h270f;
    localparam logic [SEAL_W-1:0] SEAL_RST = 7'h14;
    localparam logic [SEAL_W-1:0] SEAL_MIN = 7'h01;
    localparam logic [SEAL_W-1:0] SEAL_MAX = 7'h64;
    localparam logic [HUNT_W-1:0] HUNT_RST = 11'h0c8;
    localparam logic [HUNT_W-1:0] HUNT_MIN = 11'h00a;
    localparam logic [HUNT_W-1:0] HUNT_MAX = 11'h7cf;
    localparam logic [15:0] SHIFT_BASE = 16'h000a;

    typedef enum logic {ST_IDLE, ST_TUNE} state_t;

    // Smoothing shift: one step per factor of four in filter time
    function automatic logic [2:0] shift_for(input logic [FILT_W-1:0] t);
        logic [15:0] lim;
        logic [2:0] k;
        k = 3'h0;
        lim = SHIFT_BASE;
        if (t != FILT_RST) begin
            k = 3'h1;
            for (int i = 0; i < 5; i++) begin
                if ({2'h0, t} >= lim) begin
                    k = k + 3'h1;
                end
                lim = lim << 2;
            end
        end
        return k;
    endfunction
endpackage

// *** src/smooth_if.sv ***
// Link between sequencer and smoothing filter
`timescale 1ns/1ps
interface smooth_if;
    import filter_tune_pkg::*;
    logic in_valid;
    logic [DATA_W-1:0] in_data;
    logic [2:0] shift;
    logic out_valid;
    logic [DATA_W-1:0] out_data;
    modport ctrl(output in_valid, in_data, shift, input out_valid, out_data);
    modport filt(input in_valid, in_data, shift, output out_valid, out_data);
endinterface

// *** src/smooth_filter.sv ***
// First-order smoothing filter for the sensor input
`timescale 1ns/1ps
module smooth_filter (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    smooth_if.filt bus
);
    import filter_tune_pkg::*;

    logic [23:0] acc_reg;
    logic valid_reg;
    logic signed [24:0] diff;
    logic signed [24:0] step;
    logic [23:0] acc_next;

    // Move a fraction of the error each sample
    assign diff = $signed({1'b0, bus.in_data, 8'h00}) - $signed({1'b0, acc_reg});
    assign step = diff >>> bus.shift;
    assign acc_next = acc_reg + step[23:0];
    assign bus.out_data = acc_reg[23:8];
    assign bus.out_valid = valid_reg;

    // Accumulator
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            acc_reg <= 24'h000000;
            valid_reg <= 1'b0;
        end else if (i_clk_en) begin
            valid_reg <= bus.in_valid;
            if (bus.in_valid) begin
                acc_reg <= acc_next;
            end
        end
    end
endmodule

// *** src/filter_tune_seq.sv ***
// Input filter auto-tune sequencer with APB registers
//
// Functional notes
// - Tune enable setting, off after power-up
// - Smoothing filter time 0 to 999.9 s
// - Tuning writes filter time by itself
// - Seal period 0.1 to 10.0 s, default 2.0
// - Hunting period 10 to 1999 s, default 200
// - Tune settings shown only for PID or standard
// - Start needs PID, standard, auto, run, no input error
// - Other parameters locked while tuning
// - Run, enable, auto-tuning stay writable; mode is locked
// - Listed events cancel tuning
// - Cancelled run's filter value is discarded
// - Skip calculation if PV far or ramping
// - Lamp on when tuning starts
// - Done: lamp off, enable returns off
`timescale 1ns/1ps
module filter_tune_seq (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sensor_valid,
    input wire logic [filter_tune_pkg::DATA_W-1:0] i_sensor_data,
    input wire logic i_input_err,
    input wire logic i_sensor_err,
    input wire logic i_power_ok,
    input wire logic i_pv_near_sp,
    input wire logic i_sp_ramp,
    input wire logic i_calc_valid,
    input wire logic [filter_tune_pkg::FILT_W-1:0] i_calc_value,
    input wire logic i_calc_done,
    input wire logic i_calc_fail,
    output logic o_calc_start,
    output logic o_calc_run,
    output logic [filter_tune_pkg::SEAL_W-1:0] o_seal_period,
    output logic [filter_tune_pkg::HUNT_W-1:0] o_hunt_period,
    output logic o_filt_valid,
    output logic [filter_tune_pkg::DATA_W-1:0] o_filt_data,
    output logic o_tune_lamp,
    output logic o_irq
);
    import filter_tune_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    state_t state_reg, state_next;
    logic [5:0] ctrl_reg, ctrl_next;
    logic [1:0] mode_reg;
    logic [FILT_W-1:0] filt_reg, filt_next, saved_reg;
    logic [SEAL_W-1:0] seal_reg;
    logic [HUNT_W-1:0] hunt_reg;
    logic [2:0] irq_stat_reg, irq_mask_reg, irq_set;
    logic pready_reg, slverr_reg, irq_reg, lamp_reg, start_reg;
    logic [31:0] prdata_reg, rd_data;
    logic filt_valid_reg;
    logic [DATA_W-1:0] filt_data_reg;

    smooth_if sbus();

    ////////////////////////////////////////////////////////////////////////////
    // Control decode
    wire enable = ctrl_reg[CTRL_ENABLE_BIT];
    wire auto_sel = ctrl_reg[CTRL_AUTO_BIT];
    wire run_sel = ctrl_reg[CTRL_RUN_BIT];
    wire at_exec = ctrl_reg[CTRL_AT_BIT];
    wire level_lock = ctrl_reg[CTRL_LEVEL_BIT];
    wire pid_sel = mode_reg[MODE_PID_BIT];
    wire std_sel = mode_reg[MODE_STD_BIT];
    wire tuning = (state_reg == ST_TUNE);
    wire visible = pid_sel | std_sel;
    // Start qualification
    wire start_ok = pid_sel & std_sel & auto_sel & run_sel & ~at_exec
        & ~i_input_err;
    wire near_ok = i_pv_near_sp & ~i_sp_ramp;
    wire try_start = ~tuning & enable & start_ok;
    wire do_start = try_start & near_ok;
    wire do_skip = try_start & ~near_ok;
    // Cancel events
    wire cancel = tuning & (~enable | ~run_sel | at_exec | level_lock
        | i_sensor_err | i_calc_fail | ~i_power_ok);
    wire done = tuning & ~cancel & i_calc_done;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire acc = i_psel & i_penable;
    wire first = acc & ~pready_reg;
    wire commit = acc & pready_reg;
    wire wr_go = commit & i_pwrite & ~slverr_reg;
    wire [31:0] wd = i_pwdata;
    wire sel_ctrl = (i_paddr == ADDR_CTRL);
    wire sel_filt = (i_paddr == ADDR_FILT);
    wire sel_seal = (i_paddr == ADDR_SEAL);
    wire sel_hunt = (i_paddr == ADDR_HUNT);
    wire sel_mode = (i_paddr == ADDR_MODE);
    wire sel_stat = (i_paddr == ADDR_STAT);
    wire sel_istat = (i_paddr == ADDR_IRQ_STAT);
    wire sel_imask = (i_paddr == ADDR_IRQ_MASK);
    wire sel_fout = (i_paddr == ADDR_FILT_OUT);
    wire mapped = sel_ctrl | sel_filt | sel_seal | sel_hunt | sel_mode
        | sel_stat | sel_istat | sel_imask | sel_fout;
    // Parameters held while tuning runs
    wire locked_sel = sel_filt | sel_seal | sel_hunt | sel_mode;
    wire hidden_sel = (sel_seal | sel_hunt) & ~visible;
    // Range checks on written values
    wire filt_bad = (wd[31:FILT_W] != '0) || (wd[FILT_W-1:0] > FILT_MAX);
    wire seal_bad = (wd[31:SEAL_W] != '0) || (wd[SEAL_W-1:0] < SEAL_MIN)
        || (wd[SEAL_W-1:0] > SEAL_MAX);
    wire hunt_bad = (wd[31:HUNT_W] != '0) || (wd[HUNT_W-1:0] < HUNT_MIN)
        || (wd[HUNT_W-1:0] > HUNT_MAX);
    wire range_bad = (sel_filt & filt_bad) | (sel_seal & seal_bad)
        | (sel_hunt & hunt_bad);
    wire ro_sel = sel_stat | sel_fout;
    wire wr_err = i_pwrite & ((tuning & locked_sel) | hidden_sel | range_bad | ro_sel);
    wire err_now = ~mapped | wr_err;

    // Read mux, zeros above each field
    always_comb begin
        rd_data = 32'h00000000;
        unique case (1'b1)
            sel_ctrl: rd_data = {26'h0, ctrl_reg};
            sel_filt: rd_data = {18'h0, filt_reg};
            sel_seal: rd_data = visible ? {25'h0, seal_reg} : 32'h00000000;
            sel_hunt: rd_data = visible ? {21'h0, hunt_reg} : 32'h00000000;
            sel_mode: rd_data = {30'h0, mode_reg};
            sel_stat: rd_data = {29'h0, start_ok, visible, tuning};
            sel_istat: rd_data = {29'h0, irq_stat_reg};
            sel_imask: rd_data = {29'h0, irq_mask_reg};
            sel_fout: rd_data = {16'h0, filt_data_reg};
            default: rd_data = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        if (do_start) begin
            state_next = ST_TUNE;
        end else if (cancel | done) begin
            state_next = ST_IDLE;
        end
    end

    // Control bits: software write wins over hardware clear
    always_comb begin
        ctrl_next = ctrl_reg;
        if (done | cancel | do_skip) begin
            ctrl_next[CTRL_ENABLE_BIT] = 1'b0;
        end
        if (wr_go & sel_ctrl) begin
            ctrl_next = wd[5:0];
            if (~visible) begin
                ctrl_next[CTRL_ENABLE_BIT] = ctrl_reg[CTRL_ENABLE_BIT];
            end
        end
    end

    // Filter time: restored on cancel, updated by tuning, else software
    always_comb begin
        filt_next = filt_reg;
        if (cancel) begin
            filt_next = saved_reg;
        end else if (tuning & i_calc_valid) begin
            filt_next = (i_calc_value > FILT_MAX) ? FILT_MAX : i_calc_value;
        end else if (wr_go & sel_filt) begin
            filt_next = wd[FILT_W-1:0];
        end
    end

    // Event flags into the status register
    assign irq_set = {do_skip, cancel, done};

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer registers
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_reg <= ST_IDLE;
            ctrl_reg <= CTRL_RST;
            filt_reg <= FILT_RST;
            saved_reg <= FILT_RST;
            lamp_reg <= 1'b0;
            start_reg <= 1'b0;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            filt_reg <= filt_next;
            lamp_reg <= (state_next == ST_TUNE);
            start_reg <= do_start;
            if (do_start) begin
                saved_reg <= filt_reg;
            end
        end
    end

    // Settings registers
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            mode_reg <= MODE_RST;
            seal_reg <= SEAL_RST;
            hunt_reg <= HUNT_RST;
            irq_mask_reg <= IRQ_RST;
        end else if (i_clk_en & wr_go) begin
            if (sel_mode) mode_reg <= wd[1:0];
            if (sel_seal) seal_reg <= wd[SEAL_W-1:0];
            if (sel_hunt) hunt_reg <= wd[HUNT_W-1:0];
            if (sel_imask) irq_mask_reg <= wd[2:0];
        end
    end

    // Sticky status, write one to clear, new event wins
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            irq_stat_reg <= IRQ_RST;
            irq_reg <= 1'b0;
        end else if (i_clk_en) begin
            irq_stat_reg <= (irq_stat_reg & ~((wr_go & sel_istat) ? wd[2:0] : 3'h0))
                | irq_set;
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // APB answer: one wait state, then ready
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pready_reg <= 1'b0;
            slverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else if (i_clk_en) begin
            pready_reg <= first;
            if (first) begin
                slverr_reg <= err_now;
                prdata_reg <= i_pwrite ? 32'h00000000 : rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Smoothing filter on the sensor input
    assign sbus.in_valid = i_sensor_valid;
    assign sbus.in_data = i_sensor_data;
    assign sbus.shift = shift_for(filt_reg);

    smooth_filter u_filter (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_clk_en(i_clk_en),
        .bus(sbus.filt)
    );

    // Output staging
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            filt_valid_reg <= 1'b0;
            filt_data_reg <= 16'h0000;
        end else if (i_clk_en) begin
            filt_valid_reg <= sbus.out_valid;
            filt_data_reg <= sbus.out_data;
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = slverr_reg;
    assign o_calc_start = start_reg;
    assign o_calc_run = lamp_reg;
    assign o_tune_lamp = lamp_reg;
    assign o_seal_period = seal_reg;
    assign o_hunt_period = hunt_reg;
    assign o_filt_valid = filt_valid_reg;
    assign o_filt_data = filt_data_reg;
    assign o_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    property p_reset_off;
        $past(i_srst) |-> !enable && filt_reg == FILT_RST && !tuning;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("Not off after reset");

    property p_calc_write;
        i_clk_en && tuning && i_calc_valid && !cancel && i_calc_value <= FILT_MAX
            |=> filt_reg == $past(i_calc_value);
    endproperty
    a_calc_write: assert property (p_calc_write) else $error("Tuned value not taken");

    property p_ranges;
        seal_reg >= SEAL_MIN && seal_reg <= SEAL_MAX && hunt_reg >= HUNT_MIN
            && hunt_reg <= HUNT_MAX && filt_reg <= FILT_MAX;
    endproperty
    a_ranges: assert property (p_ranges) else $error("Setting out of range");

    property p_hidden;
        i_clk_en && first && !visible && (sel_seal || sel_hunt)
            |=> o_pslverr || o_prdata == 32'h00000000;
    endproperty
    a_hidden: assert property (p_hidden) else $error("Hidden setting reachable");

    property p_start_cond;
        $rose(o_tune_lamp) |-> $past(start_ok) && $past(near_ok) && $past(enable);
    endproperty
    a_start_cond: assert property (p_start_cond) else $error("Bad tuning start");

    property p_lock;
        i_clk_en && first && tuning && i_pwrite && sel_mode |=> o_pslverr ##1 mode_reg == $past(mode_reg, 2);
    endproperty
    a_lock: assert property (p_lock) else $error("Locked write accepted");

    property p_ctrl_free;
        i_clk_en && first && tuning && i_pwrite && sel_ctrl |=> !o_pslverr;
    endproperty
    a_ctrl_free: assert property (p_ctrl_free) else $error("Control write refused");

    property p_cancel;
        i_clk_en && cancel |=> !tuning && !o_tune_lamp && filt_reg == $past(saved_reg);
    endproperty
    a_cancel: assert property (p_cancel) else $error("Cancel not handled");

    property p_skip;
        i_clk_en && !tuning && enable && start_ok && !near_ok && !(wr_go && sel_ctrl)
            |=> !tuning && !enable;
    endproperty
    a_skip: assert property (p_skip) else $error("Started while far or ramping");

    property p_done;
        i_clk_en && done && !(wr_go && sel_ctrl) |=> !o_tune_lamp && !enable;
    endproperty
    a_done: assert property (p_done) else $error("Done not handled");

    property p_irq;
        i_clk_en |=> o_irq == |($past(irq_stat_reg) & $past(irq_mask_reg));
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt mismatch");

    c_start: cover property (i_clk_en && do_start);
    c_done: cover property (i_clk_en && done);
    c_cancel: cover property (i_clk_en && cancel);
    c_skip: cover property (i_clk_en && do_skip);
endmodule

// *** bench/ft_host_model.sv ***
// Operator or host model writing parameters over APB
`timescale 1ns/1ps
module ft_host_model (
    input wire logic i_core_clk,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata
);
    // Idle bus from time zero
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end

    // One transfer, held until pready is sampled high or 20 clocks pass
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rdata, output logic err, output logic hung);
        int n;
        n = 0;
        @(posedge i_core_clk);
        o_psel <= 1'b1;
        o_pwrite <= wr;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_core_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (i_pready !== 1'b1 && n < 20);
        rdata = i_prdata;
        err = i_pslverr;
        hung = (i_pready !== 1'b1);
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_pwdata <= ~d; // Released data stops showing the last value
    endtask
endmodule

// *** bench/input_filter_autotune_sequencer_bench.sv ***
// Self-checking bench for the input filter auto-tune sequencer
`timescale 1ns/1ps
module input_filter_autotune_sequencer_bench;
    import filter_tune_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic sens_valid = 1'b0;
    logic [DATA_W-1:0] sens_data = 16'h0000;
    logic input_err = 1'b0;
    logic sensor_err = 1'b0;
    logic power_ok = 1'b1;
    logic pv_near = 1'b1;
    logic sp_ramp = 1'b0;
    logic calc_valid = 1'b0;
    logic [FILT_W-1:0] calc_value = 14'h0000;
    logic calc_done = 1'b0;
    logic calc_fail = 1'b0;
    logic clk_en = 1'b1;
    logic calc_start, calc_run, filt_valid, lamp, irq;
    logic [SEAL_W-1:0] seal;
    logic [HUNT_W-1:0] hunt;
    logic [DATA_W-1:0] filt_data;
    int fail_count = 0;
    int checked = 0;

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Host model and design
    ft_host_model host (.i_core_clk(clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata));
    filter_tune_seq DUT (.i_core_clk(clk), .i_srst(srst), .i_clk_en(clk_en),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sensor_valid(sens_valid), .i_sensor_data(sens_data), .i_input_err(input_err),
        .i_sensor_err(sensor_err), .i_power_ok(power_ok), .i_pv_near_sp(pv_near),
        .i_sp_ramp(sp_ramp), .i_calc_valid(calc_valid), .i_calc_value(calc_value),
        .i_calc_done(calc_done), .i_calc_fail(calc_fail), .o_calc_start(calc_start),
        .o_calc_run(calc_run), .o_seal_period(seal), .o_hunt_period(hunt),
        .o_filt_valid(filt_valid), .o_filt_data(filt_data), .o_tune_lamp(lamp),
        .o_irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and shared helpers
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic hung;
        host.xfer(w, a, d, r, e, hung);
        if (hung) begin
            check("apb ready", 32'h0, 32'h1);
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] r;
        logic e;
        acc(1'b1, a, d, r, e);
        check("write error", {31'h0, e}, {31'h0, xe});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        acc(1'b0, a, 32'h0, r, e);
        check("read data", r, x);
        check("read error", {31'h0, e}, {31'h0, xe});
    endtask

    // Bounded wait for the lamp level
    task automatic wait_lamp(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (lamp !== lvl && n < 40);
        check("tune lamp", {31'h0, lamp}, {31'h0, lvl});
        if (lamp !== lvl) close_out();
    endtask

    task automatic no_start();
        repeat (20) @(negedge clk);
        check("lamp idle", {31'h0, lamp}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_defaults();
        check("seal out", {25'h0, seal}, {25'h0, SEAL_RST});
        check("hunt out", {21'h0, hunt}, {21'h0, HUNT_RST});
        rd(ADDR_CTRL, 32'h0, 1'b0);
        rd(ADDR_FILT, 32'h0, 1'b0);
        rd(ADDR_SEAL, 32'h14, 1'b0);
        rd(ADDR_HUNT, 32'hc8, 1'b0);
        rd(8'h24, 32'h0, 1'b1);
        wr(ADDR_STAT, 32'h1, 1'b1);
        $display("test defaults done");
    endtask

    task automatic t_ranges();
        logic [7:0] ta [10] = '{ADDR_FILT, ADDR_FILT, ADDR_SEAL, ADDR_SEAL, ADDR_SEAL,
            ADDR_SEAL, ADDR_HUNT, ADDR_HUNT, ADDR_HUNT, ADDR_HUNT};
        logic [31:0] td [10] = '{32'h2710, 32'h270f, 32'h0, 32'h1, 32'h65, 32'h64,
            32'h9, 32'ha, 32'h7d0, 32'h7cf};
        logic te [10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 10; i++) begin
            wr(ta[i], td[i], te[i]);
        end
        rd(ADDR_FILT, 32'h270f, 1'b0);
        rd(ADDR_SEAL, 32'h64, 1'b0);
        rd(ADDR_HUNT, 32'h7cf, 1'b0);
        check("seal out", {25'h0, seal}, 32'h64);
        wr(ADDR_SEAL, 32'h14, 1'b0);
        wr(ADDR_HUNT, 32'hc8, 1'b0);
        $display("test ranges done");
    endtask

    task automatic t_modes();
        logic [31:0] r;
        logic e;
        wr(ADDR_MODE, 32'h0, 1'b0);
        wr(ADDR_SEAL, 32'h14, 1'b1);
        acc(1'b1, ADDR_CTRL, 32'h07, r, e);
        rd(ADDR_CTRL, 32'h06, 1'b0);
        for (int m = 1; m < 3; m++) begin
            wr(ADDR_MODE, m, 1'b0);
            wr(ADDR_CTRL, 32'h07, 1'b0);
            no_start();
            wr(ADDR_CTRL, 32'h0, 1'b0);
        end
        wr(ADDR_MODE, 32'h3, 1'b0);
        wr(ADDR_CTRL, 32'h05, 1'b0);
        no_start();
        $display("test modes done");
    endtask

    task automatic t_tune_done();
        wr(ADDR_FILT, 32'h5, 1'b0);
        wr(ADDR_CTRL, 32'h0e, 1'b0);
        wr(ADDR_CTRL, 32'h06, 1'b0);
        @(posedge clk);
        input_err <= 1'b1;
        wr(ADDR_CTRL, 32'h07, 1'b0);
        no_start();
        @(posedge clk);
        input_err <= 1'b0;
        wait_lamp(1'b1);
        check("calc start", {31'h0, calc_start}, 32'h1);
        @(negedge clk);
        check("calc start end", {31'h0, calc_start}, 32'h0);
        check("calc run", {31'h0, calc_run}, 32'h1);
        wr(ADDR_FILT, 32'h9, 1'b1);
        wr(ADDR_SEAL, 32'h14, 1'b1);
        wr(ADDR_MODE, 32'h1, 1'b1);
        wr(ADDR_CTRL, 32'h07, 1'b0);
        @(posedge clk);
        calc_valid <= 1'b1;
        calc_value <= 14'h007b;
        @(posedge clk);
        calc_valid <= 1'b0;
        rd(ADDR_FILT, 32'h7b, 1'b0);
        @(posedge clk);
        calc_done <= 1'b1;
        @(posedge clk);
        calc_done <= 1'b0;
        wait_lamp(1'b0);
        rd(ADDR_CTRL, 32'h06, 1'b0);
        rd(ADDR_FILT, 32'h7b, 1'b0);
        rd(ADDR_IRQ_STAT, 32'h1, 1'b0);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h7, 1'b0);
        repeat (2) @(negedge clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(ADDR_IRQ_STAT, 32'h1, 1'b0);
        repeat (2) @(negedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test tune done");
    endtask

    task automatic t_cancel();
        for (int c = 0; c < 7; c++) begin
            wr(ADDR_FILT, 32'h7, 1'b0);
            wr(ADDR_CTRL, 32'h07, 1'b0);
            wait_lamp(1'b1);
            @(posedge clk);
            calc_valid <= 1'b1;
            calc_value <= 14'h0037;
            @(posedge clk);
            calc_valid <= 1'b0;
            case (c)
                0: wr(ADDR_CTRL, 32'h06, 1'b0);
                1: wr(ADDR_CTRL, 32'h03, 1'b0);
                2: wr(ADDR_CTRL, 32'h0f, 1'b0);
                3: wr(ADDR_CTRL, 32'h17, 1'b0);
                4: sensor_err <= 1'b1;
                5: calc_fail <= 1'b1;
                default: power_ok <= 1'b0;
            endcase
            wait_lamp(1'b0);
            @(posedge clk);
            sensor_err <= 1'b0;
            calc_fail <= 1'b0;
            power_ok <= 1'b1;
            wr(ADDR_CTRL, 32'h06, 1'b0);
            rd(ADDR_FILT, 32'h7, 1'b0);
            rd(ADDR_IRQ_STAT, 32'h2, 1'b0);
            wr(ADDR_IRQ_STAT, 32'h2, 1'b0);
        end
        $display("test cancel done");
    endtask

    task automatic t_skip();
        for (int c = 0; c < 2; c++) begin
            @(posedge clk);
            pv_near <= (c != 0);
            sp_ramp <= (c != 0);
            wr(ADDR_CTRL, 32'h07, 1'b0);
            no_start();
            rd(ADDR_CTRL, 32'h06, 1'b0);
            rd(ADDR_FILT, 32'h7, 1'b0);
            rd(ADDR_IRQ_STAT, 32'h4, 1'b0);
            wr(ADDR_IRQ_STAT, 32'h4, 1'b0);
        end
        @(posedge clk);
        pv_near <= 1'b1;
        sp_ramp <= 1'b0;
        $display("test skip done");
    endtask

    task automatic t_filter();
        int n;
        n = 0;
        wr(ADDR_FILT, 32'h0, 1'b0);
        @(posedge clk);
        clk_en <= 1'b0;
        sens_valid <= 1'b1;
        sens_data <= 16'h1234;
        repeat (3) @(negedge clk);
        check("frozen valid", {31'h0, filt_valid}, 32'h0);
        @(posedge clk);
        clk_en <= 1'b1;
        @(posedge clk);
        sens_valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (filt_valid !== 1'b1 && n < 6);
        check("filter valid", {31'h0, filt_valid}, 32'h1);
        check("filter data", {16'h0, filt_data}, 32'h1234);
        rd(ADDR_FILT_OUT, 32'h1234, 1'b0);
        $display("test filter done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        t_defaults();
        t_ranges();
        t_modes();
        t_tune_done();
        t_cancel();
        t_skip();
        t_filter();
        close_out();
    end
endmodule
